// ===== hdl/radio_mode_irq_enable_regs.sv
// Radio mode control, second interrupt enable and crystal trim registers.
// Assumes a classic Wishbone master and radio core logic on clk_i.
`include "radio_mode_irq_enable_regs_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module radio_mode_irq_enable_regs #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Wishbone slave
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [ADDR_W-1:0]   adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic      [31:0]         dat_o,
  output logic                     ack_o,
  // Radio core status and events
  input  wire logic [7:0]          irq_status_i,
  input  wire logic                preamble_det_mode_i,
  input  wire logic                fifo_mode_i,
  input  wire logic                packet_sent_i,
  input  wire logic                packet_valid_i,
  input  wire logic                tx_data_started_i,
  input  wire logic                unmod_carrier_i,
  input  wire logic                tx_fifo_almost_full_i,
  input  wire logic                diversity_ant_sel_i,
  // Controls to the radio core
  output logic                     irq_n_o,
  output logic                     soft_reset_o,
  output logic                     low_batt_detect_en_o,
  output logic                     wake_timer_en_o,
  output logic                     slow_osc_source_sel_o,
  output logic                     tx_on_o,
  output logic                     rx_on_o,
  output logic                     synth_idle_en_o,
  output logic                     xtal_en_o,
  output logic                     diversity_en_o,
  output logic                     diversity_beacon_o,
  output logic                     multi_packet_o,
  output logic                     auto_tx_o,
  output logic                     low_duty_en_o,
  output logic                     receive_fifo_clear_o,
  output logic                     transmit_fifo_clear_o,
  output logic [6:0]               xtal_trim_fine_o,
  output logic                     xtal_trim_coarse_o,
  // Antenna select pins
  output logic                     ant1_o,
  output logic                     ant2_o
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // The highest register sits at byte 0x24, so fewer address bits cannot decode it
  if (ADDR_W < 6) begin : g_addr_check
    $error("ADDR_W too small for register map");
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    logic [9:0] byte_addr;
    byte_addr = {idx, 2'b00};
    return a == ADDR_W'(byte_addr);
  endfunction : addr_hit

  logic ack_reg;
  logic [31:0] dat_reg;

  wire       bus_new   = cyc_i & stb_i & ~ack_reg;
  wire       wr_stb    = bus_new & we_i & sel_i[0];
  wire       hit_ien   = addr_hit(adr_i, `IDX_IRQ_ENABLE_SECOND);
  wire       hit_mc1   = addr_hit(adr_i, `IDX_MODE_CONTROL_FIRST);
  wire       hit_mc2   = addr_hit(adr_i, `IDX_MODE_CONTROL_SECOND);
  wire       hit_trim  = addr_hit(adr_i, `IDX_CRYSTAL_LOAD_TRIM);
  wire       wr_ien    = wr_stb & hit_ien;
  wire       wr_mc1    = wr_stb & hit_mc1;
  wire       wr_mc2    = wr_stb & hit_mc2;
  wire       wr_trim   = wr_stb & hit_trim;
  wire [7:0] wd        = dat_i[7:0];
  wire [6:0] wd_fine   = dat_i[6:0];

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [4:0] ien_reg;
  radio_mode_irq_enable_regs_pkg::reg8_t mc1_reg;
  radio_mode_irq_enable_regs_pkg::reg8_t mc2_reg;
  radio_mode_irq_enable_regs_pkg::reg8_t trim_reg;

  localparam radio_mode_irq_enable_regs_pkg::reg8_t IEN_RST  = `RST_IRQ_ENABLE_SECOND;
  localparam radio_mode_irq_enable_regs_pkg::reg8_t MC1_RST  = `RST_MODE_CONTROL_FIRST;
  localparam radio_mode_irq_enable_regs_pkg::reg8_t MC2_RST  = `RST_MODE_CONTROL_SECOND;
  localparam radio_mode_irq_enable_regs_pkg::reg8_t TRIM_RST = `RST_CRYSTAL_LOAD_TRIM;

  // Soft reset never stores, so its bit always reads back as zero
  wire sw_rst    = wr_mc1 & wd[`MC1_SOFT_RESET];
  wire any_rst   = rst_i | sw_rst;

  // Upper enables follow the preamble detect mode and cannot be written
  wire [7:0] en_vec = {{3{preamble_det_mode_i}}, ien_reg};

  // ----------------------------------------
  // Transmit and receive on
  // ----------------------------------------
  wire tx_cur      = mc1_reg[`MC1_TX_ON];
  wire rx_cur      = mc1_reg[`MC1_RX_ON];
  wire multi_pkt   = mc2_reg[`MC2_MULTI_PKT];
  wire auto_tx     = mc2_reg[`MC2_AUTO_TX];
  // Abort of a frame with nothing sent yet is honoured only on a plain carrier
  wire abort_ok    = tx_data_started_i | unmod_carrier_i;
  wire auto_set    = auto_tx & tx_fifo_almost_full_i;
  wire tx_hw_clr   = fifo_mode_i & packet_sent_i;
  wire rx_hw_clr   = packet_valid_i & ~multi_pkt;
  wire tx_sw_val   = wd[`MC1_TX_ON] | (tx_cur & ~abort_ok);
  // A software write wins, then the automatic start, then the hardware clear
  wire tx_next     = wr_mc1 ? tx_sw_val :
                     auto_set ? 1'b1 :
                     tx_hw_clr ? 1'b0 : tx_cur;
  wire rx_next     = wr_mc1 ? wd[`MC1_RX_ON] :
                     rx_hw_clr ? 1'b0 : rx_cur;
  wire [7:0] mc1_next = wr_mc1 ? {1'b0, wd[6:4], tx_next, rx_next, wd[1:0]}
                               : {1'b0, mc1_reg[6:4], tx_next, rx_next, mc1_reg[1:0]};

  // ----------------------------------------
  // FIFO clear sequence
  // ----------------------------------------
  // Clear fires on the second write, which returns a stored one to zero
  wire rxf_clr = wr_mc2 & mc2_reg[`MC2_RX_FIFO_CLR] & ~wd[`MC2_RX_FIFO_CLR];
  wire txf_clr = wr_mc2 & mc2_reg[`MC2_TX_FIFO_CLR] & ~wd[`MC2_TX_FIFO_CLR];

  // ----------------------------------------
  // Antenna selection
  // ----------------------------------------
  radio_mode_irq_enable_regs_pkg::ant_code_t ant_code;
  assign ant_code = mc2_reg[`MC2_ANT_DIV_HI:`MC2_ANT_DIV_LO];
  wire radio_busy = tx_cur | rx_cur;
  wire ant_fixed1 = ant_code[2] ? diversity_ant_sel_i : ant_code[0];
  wire ant_idle   = ant_code[2] ? ant_code[0] : ant_code[1];
  wire ant1_next  = radio_busy ? ant_fixed1 : ant_idle;
  wire ant2_next  = radio_busy ? ~ant_fixed1 : ant_idle;

  // ----------------------------------------
  // Interrupt gate
  // ----------------------------------------
  // Each source reaches the pin only while its enable and status are both high
  wire irq_any = |(irq_status_i & en_vec);

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [7:0] rd_byte = hit_ien  ? en_vec :
                       hit_mc1  ? mc1_reg :
                       hit_mc2  ? mc2_reg :
                       hit_trim ? trim_reg : 8'h00;

  // ----------------------------------------
  // Bus response
  // ----------------------------------------
  // One wait-free answer: ack follows the request by one edge, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_new;
      if (bus_new && !we_i) begin
        dat_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ----------------------------------------
  // Register updates
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      ien_reg  <= IEN_RST[`IEN_WRITABLE_HI:0];
      mc1_reg  <= MC1_RST;
      mc2_reg  <= MC2_RST;
      trim_reg <= TRIM_RST;
    end else begin
      mc1_reg <= mc1_next;
      if (wr_ien) begin
        ien_reg <= wd[`IEN_WRITABLE_HI:0];
      end
      if (wr_mc2) begin
        mc2_reg <= wd;
      end
      if (wr_trim) begin
        trim_reg <= wd;
      end
    end
  end

  // ----------------------------------------
  // Pulses, interrupt pin and antenna pins
  // ----------------------------------------
  logic soft_rst_reg;
  logic rxf_clr_reg;
  logic txf_clr_reg;
  logic irq_n_reg;
  logic ant1_reg;
  logic ant2_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_rst_reg <= 1'b0;
      rxf_clr_reg  <= 1'b0;
      txf_clr_reg  <= 1'b0;
      irq_n_reg    <= 1'b1;
      ant1_reg     <= 1'b0;
      ant2_reg     <= 1'b0;
    end else begin
      soft_rst_reg <= sw_rst;
      rxf_clr_reg  <= rxf_clr;
      txf_clr_reg  <= txf_clr;
      irq_n_reg    <= ~irq_any;
      ant1_reg     <= ant1_next;
      ant2_reg     <= ant2_next;
    end
  end

  // ----------------------------------------
  // Output assignment
  // ----------------------------------------
  assign ack_o                 = ack_reg;
  assign dat_o                 = dat_reg;
  assign irq_n_o               = irq_n_reg;
  assign soft_reset_o          = soft_rst_reg;
  assign low_batt_detect_en_o  = mc1_reg[`MC1_LOW_BATT_EN];
  assign wake_timer_en_o       = mc1_reg[`MC1_WAKE_TMR_EN];
  assign slow_osc_source_sel_o = mc1_reg[`MC1_SLOW_OSC_SEL];
  assign tx_on_o               = tx_cur;
  assign rx_on_o               = rx_cur;
  assign synth_idle_en_o       = mc1_reg[`MC1_SYNTH_ON];
  assign xtal_en_o             = mc1_reg[`MC1_XTAL_ON];
  assign diversity_en_o        = ant_code[2];
  assign diversity_beacon_o    = ant_code[2] & ant_code[1];
  assign multi_packet_o        = multi_pkt;
  assign auto_tx_o             = auto_tx;
  assign low_duty_en_o         = mc2_reg[`MC2_LOW_DUTY_EN];
  assign receive_fifo_clear_o  = rxf_clr_reg;
  assign transmit_fifo_clear_o = txf_clr_reg;
  assign xtal_trim_fine_o      = trim_reg[6:0];
  assign xtal_trim_coarse_o    = trim_reg[`TRIM_COARSE];
  assign ant1_o                = ant1_reg;
  assign ant2_o                = ant2_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Write data of the previous edge, so checks can see what a write stored
  logic [7:0] wd_last;
  always_ff @(posedge clk_i) begin
    wd_last <= wd;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  wut_masked_a: assert property ((irq_status_i == 8'h08) && !en_vec[3] |=> irq_n_o)
    else $error("wake timer interrupt not masked");

  batt_enabled_a: assert property ((irq_status_i == 8'h04) && en_vec[2] |=> !irq_n_o)
    else $error("battery interrupt not signalled");

  rssi_enabled_a: assert property ((irq_status_i == 8'h10) && en_vec[4] |=> !irq_n_o)
    else $error("signal strength interrupt not signalled");

  irq_gate_a: assert property (!(|(irq_status_i & en_vec)) |=> irq_n_o)
    else $error("interrupt without enabled status");

  upper_ro_a: assert property (bus_new && !we_i && hit_ien |=> dat_o[7:5] == {3{$past(preamble_det_mode_i)}})
    else $error("upper enables not read only");

  soft_reset_a: assert property (sw_rst |=> (mc1_reg == MC1_RST) && (mc2_reg == MC2_RST)
                                 && (trim_reg == TRIM_RST) ##1 !soft_reset_o)
    else $error("soft reset did not restore defaults");

  tx_autoclr_a: assert property (tx_hw_clr && !wr_mc1 && !auto_set |=> !tx_on_o)
    else $error("transmit on not cleared after packet");

  tx_abort_a: assert property (wr_mc1 && !sw_rst && !wd[3] && tx_cur && !abort_ok |=> tx_on_o)
    else $error("abort accepted without carrier");

  rx_autoclr_a: assert property (packet_valid_i && !multi_pkt && !wr_mc1 |=> !rx_on_o)
    else $error("receive on not cleared after packet");

  ant_idle_a: assert property (!radio_busy && ant_code == 3'b010 |=> ant1_o && ant2_o)
    else $error("idle antenna levels wrong");

  fifo_clr_a: assert property (rxf_clr |=> receive_fifo_clear_o ##1 !receive_fifo_clear_o)
    else $error("receive FIFO clear pulse wrong");

  trim_write_a: assert property (wr_trim && !sw_rst |=> xtal_trim_fine_o == $past(wd_fine))
    else $error("trim field not written");

  ack_answer_a: assert property (bus_new |=> ack_o)
    else $error("bus request not answered");

  wut_enabled_a: assert property ((irq_status_i == 8'h08) && en_vec[3] |=> !irq_n_o)
    else $error("wake timer interrupt not signalled");

  ready_por_a: assert property (|(irq_status_i[1:0] & en_vec[1:0]) |=> !irq_n_o)
    else $error("ready or power-on interrupt not signalled");

  batt_mon_a: assert property (wr_mc1 && !sw_rst |=> low_batt_detect_en_o == wd_last[`MC1_LOW_BATT_EN])
    else $error("battery monitor enable not written");

  wake_tmr_a: assert property (wr_mc1 && !sw_rst |=> wake_timer_en_o == wd_last[`MC1_WAKE_TMR_EN])
    else $error("wake timer enable not written");

  osc_sel_a: assert property (wr_mc1 && !sw_rst |=> slow_osc_source_sel_o == wd_last[`MC1_SLOW_OSC_SEL])
    else $error("slow oscillator select not written");

  tune_ready_a: assert property (wr_mc1 && !sw_rst |=> {synth_idle_en_o, xtal_en_o} == wd_last[1:0])
    else $error("tune or ready mode not written");

  rx_multi_a: assert property (packet_valid_i && multi_pkt && rx_cur && !wr_mc1 |=> rx_on_o)
    else $error("receive left although multi-packet set");

  auto_tx_a: assert property (auto_set && !wr_mc1 |=> tx_on_o)
    else $error("automatic transmit did not start");

  low_duty_a: assert property (wr_mc2 |=> low_duty_en_o == wd_last[`MC2_LOW_DUTY_EN])
    else $error("low duty cycle enable not written");

  ant_busy_a: assert property (radio_busy && ant_code == 3'b001 |=> ant1_o && !ant2_o)
    else $error("busy antenna levels wrong");

  ant_div_a: assert property (radio_busy && ant_code[2] |=> ant1_o == $past(diversity_ant_sel_i))
    else $error("diversity antenna choice not followed");

  ant_div_idle_a: assert property (!radio_busy && ant_code == 3'b101 |=> ant1_o && ant2_o)
    else $error("idle diversity antenna levels wrong");

  tx_fifo_clr_a: assert property (txf_clr |=> transmit_fifo_clear_o ##1 !transmit_fifo_clear_o)
    else $error("transmit FIFO clear pulse wrong");

  trim_coarse_a: assert property (wr_trim && !sw_rst |=> xtal_trim_coarse_o == wd_last[`TRIM_COARSE])
    else $error("coarse trim bit not written");

  soft_reset_c: cover property (sw_rst ##1 soft_reset_o);
  auto_tx_c:    cover property (!tx_cur && auto_set ##1 tx_on_o);
  fifo_clr_c:   cover property (wr_mc2 && wd[1] ##[1:8] rxf_clr);
  irq_c:        cover property (irq_n_o ##1 !irq_n_o);
  rx_multi_c:   cover property (packet_valid_i && multi_pkt && rx_cur ##1 rx_on_o);

endmodule : radio_mode_irq_enable_regs

`default_nettype wire

// ===== hdl/radio_mode_irq_enable_regs_cfg.svh
// Constants for the radio mode and interrupt enable register group.
// Assumes it is included by its bare name from hdl/.
`ifndef RADIO_MODE_IRQ_ENABLE_REGS_CFG_SVH
`define RADIO_MODE_IRQ_ENABLE_REGS_CFG_SVH

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define IDX_IRQ_ENABLE_SECOND   8'h06
`define IDX_MODE_CONTROL_FIRST  8'h07
`define IDX_MODE_CONTROL_SECOND 8'h08
`define IDX_CRYSTAL_LOAD_TRIM   8'h09

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_IRQ_ENABLE_SECOND   8'h03
`define RST_MODE_CONTROL_FIRST  8'h01
`define RST_MODE_CONTROL_SECOND 8'h00
`define RST_CRYSTAL_LOAD_TRIM   8'h7F

// ----------------------------------------
// Field positions: mode control first
// ----------------------------------------
`define MC1_SOFT_RESET   7
`define MC1_LOW_BATT_EN  6
`define MC1_WAKE_TMR_EN  5
`define MC1_SLOW_OSC_SEL 4
`define MC1_TX_ON        3
`define MC1_RX_ON        2
`define MC1_SYNTH_ON     1
`define MC1_XTAL_ON      0

// ----------------------------------------
// Field positions: mode control second and trim
// ----------------------------------------
`define MC2_ANT_DIV_HI   7
`define MC2_ANT_DIV_LO   5
`define MC2_MULTI_PKT    4
`define MC2_AUTO_TX      3
`define MC2_LOW_DUTY_EN  2
`define MC2_RX_FIFO_CLR  1
`define MC2_TX_FIFO_CLR  0
`define TRIM_COARSE      7
`define IEN_WRITABLE_HI  4

`endif

// ===== hdl/radio_mode_irq_enable_regs_pkg.sv
// Types shared by the radio mode and interrupt enable register group.
// Assumes nothing of its surroundings.
package radio_mode_irq_enable_regs_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic [2:0] ant_code_t;
endpackage : radio_mode_irq_enable_regs_pkg

// ===== verif/testbench.sv
// Self-checking bench for the radio mode and interrupt enable registers.
// Assumes the design's classic Wishbone slave, one clock and synchronous reset.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000, dat_o;
  logic        ack_o, irq_n_o, soft_reset_o, low_batt_detect_en_o, wake_timer_en_o, slow_osc_source_sel_o;
  logic        tx_on_o, rx_on_o, synth_idle_en_o, xtal_en_o, diversity_en_o, diversity_beacon_o;
  logic        multi_packet_o, auto_tx_o, low_duty_en_o, receive_fifo_clear_o, transmit_fifo_clear_o;
  logic [6:0]  xtal_trim_fine_o;
  logic        xtal_trim_coarse_o, ant1_o, ant2_o;
  logic [7:0]  irq_status_i = 8'h00;
  logic        preamble_det_mode_i = 1'b0, fifo_mode_i = 1'b0, packet_sent_i = 1'b0, packet_valid_i = 1'b0;
  logic        tx_data_started_i = 1'b0, unmod_carrier_i = 1'b0, tx_fifo_almost_full_i = 1'b0;
  logic        diversity_ant_sel_i = 1'b1;
  logic [2:0]  pulses;
  logic [31:0] q;
  int          err_count = 0, total_checks = 0, cycles = 0;

  always #2 clk_i = ~clk_i;

  radio_mode_irq_enable_regs #(.ADDR_W(8)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_status_i(irq_status_i),
    .preamble_det_mode_i(preamble_det_mode_i), .fifo_mode_i(fifo_mode_i), .packet_sent_i(packet_sent_i),
    .packet_valid_i(packet_valid_i), .tx_data_started_i(tx_data_started_i), .unmod_carrier_i(unmod_carrier_i),
    .tx_fifo_almost_full_i(tx_fifo_almost_full_i), .diversity_ant_sel_i(diversity_ant_sel_i),
    .irq_n_o(irq_n_o), .soft_reset_o(soft_reset_o), .low_batt_detect_en_o(low_batt_detect_en_o),
    .wake_timer_en_o(wake_timer_en_o), .slow_osc_source_sel_o(slow_osc_source_sel_o), .tx_on_o(tx_on_o),
    .rx_on_o(rx_on_o), .synth_idle_en_o(synth_idle_en_o), .xtal_en_o(xtal_en_o),
    .diversity_en_o(diversity_en_o), .diversity_beacon_o(diversity_beacon_o), .multi_packet_o(multi_packet_o),
    .auto_tx_o(auto_tx_o), .low_duty_en_o(low_duty_en_o), .receive_fifo_clear_o(receive_fifo_clear_o),
    .transmit_fifo_clear_o(transmit_fifo_clear_o), .xtal_trim_fine_o(xtal_trim_fine_o),
    .xtal_trim_coarse_o(xtal_trim_coarse_o), .ant1_o(ant1_o), .ant2_o(ant2_o));

  // ----------------------------------------
  // Common tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Pulses seen in the ack cycle: soft reset, receive clear, transmit clear
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    pulses = {soft_reset_o, receive_fifo_clear_o, transmit_fifo_clear_o};
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 4'h1);
  endtask : wr

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  // Drives one-cycle event pulses: bit 1 packet sent, bit 0 valid packet
  task automatic ev(input logic [1:0] k);
    @(posedge clk_i);
    {packet_sent_i, packet_valid_i} <= k;
    @(posedge clk_i);
    {packet_sent_i, packet_valid_i} <= 2'b00;
    step(1);
  endtask : ev

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_defaults;
    wb(1'b0, 8'h18, 8'h00, 4'h1); check(q, 32'h0000_0003);
    wb(1'b0, 8'h1c, 8'h00, 4'h1); check(q, 32'h0000_0001);
    wb(1'b0, 8'h20, 8'h00, 4'h1); check(q, 32'h0000_0000);
    wb(1'b0, 8'h24, 8'h00, 4'h1); check(q, 32'h0000_007f);
    wr(8'h28, 8'h5a);
    wb(1'b0, 8'h28, 8'h00, 4'h1); check(q, 32'h0000_0000);
    wb(1'b1, 8'h24, 8'h12, 4'h0);
    wb(1'b0, 8'h24, 8'h00, 4'h1); check(q, 32'h0000_007f);
  endtask : t_defaults

  task automatic t_irq;
    for (int i = 0; i < 5; i++) begin
      wr(8'h18, 8'(1 << i));
      @(posedge clk_i);
      irq_status_i <= 8'(1 << i);
      step(1); check(32'(irq_n_o), 32'h0000_0000);
      @(posedge clk_i);
      irq_status_i <= ~8'(1 << i);
      step(1); check(32'(irq_n_o), 32'h0000_0001);
    end
    wr(8'h18, 8'hff);
    wb(1'b0, 8'h18, 8'h00, 4'h1); check(q, 32'h0000_001f);
    irq_status_i <= 8'he0;
    wr(8'h18, 8'h00);
    step(1); check(32'(irq_n_o), 32'h0000_0001);
    @(posedge clk_i);
    preamble_det_mode_i <= 1'b1;
    step(2); check(32'(irq_n_o), 32'h0000_0000);
    wb(1'b0, 8'h18, 8'h00, 4'h1); check(q, 32'h0000_00e0);
    preamble_det_mode_i <= 1'b0;
    irq_status_i <= 8'h00;
  endtask : t_irq

  task automatic t_mode_soft_reset;
    wr(8'h1c, 8'h72);
    step(1);
    check(32'({low_batt_detect_en_o, wake_timer_en_o, slow_osc_source_sel_o, tx_on_o,
               rx_on_o, synth_idle_en_o, xtal_en_o}), 32'h0000_0072);
    wr(8'h18, 8'h0c);
    wr(8'h20, 8'h1c);
    wr(8'h24, 8'h11);
    wr(8'h1c, 8'hf2);
    check(32'(pulses), 32'h0000_0004);
    wb(1'b0, 8'h1c, 8'h00, 4'h1); check(q, 32'h0000_0001);
    wb(1'b0, 8'h18, 8'h00, 4'h1); check(q, 32'h0000_0003);
    wb(1'b0, 8'h20, 8'h00, 4'h1); check(q, 32'h0000_0000);
    wb(1'b0, 8'h24, 8'h00, 4'h1); check(q, 32'h0000_007f);
  endtask : t_mode_soft_reset

  task automatic t_rx_tx;
    wr(8'h1c, 8'h05);
    ev(2'b01); check(32'(rx_on_o), 32'h0000_0000);
    wr(8'h20, 8'h10);
    wr(8'h1c, 8'h05);
    ev(2'b01); check(32'({multi_packet_o, rx_on_o}), 32'h0000_0003);
    @(posedge clk_i);
    fifo_mode_i <= 1'b1;
    wr(8'h1c, 8'h09);
    wr(8'h1c, 8'h01);
    step(1); check(32'(tx_on_o), 32'h0000_0001);
    ev(2'b10); check(32'(tx_on_o), 32'h0000_0000);
    wr(8'h20, 8'h08);
    tx_fifo_almost_full_i <= 1'b1;
    step(2); check(32'({auto_tx_o, tx_on_o}), 32'h0000_0003);
    @(posedge clk_i);
    tx_fifo_almost_full_i <= 1'b0;
    ev(2'b10); check(32'(tx_on_o), 32'h0000_0000);
    wr(8'h20, 8'h04);
    wr(8'h1c, 8'h09);
    unmod_carrier_i <= 1'b1;
    wr(8'h1c, 8'h01);
    step(1); check(32'({low_duty_en_o, tx_on_o}), 32'h0000_0002);
    wr(8'h1c, 8'h09);
    tx_data_started_i <= 1'b1;
    unmod_carrier_i <= 1'b0;
    wr(8'h1c, 8'h01);
    step(1); check(32'(tx_on_o), 32'h0000_0000);
    @(posedge clk_i);
    tx_data_started_i <= 1'b0;
    fifo_mode_i <= 1'b0;
  endtask : t_rx_tx

  // Idle and busy antenna levels for every diversity code
  // Busy levels use a diversity choice equal to code bit 1, so both choices occur
  task automatic t_antenna;
    logic [2:0] c;
    logic       b;
    logic [7:0] idle_tab;
    logic [7:0] busy_tab;
    idle_tab = 8'hac;
    busy_tab = 8'hca;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      b = idle_tab[i];
      wr(8'h1c, 8'h01);
      wr(8'h20, {c, 5'h00});
      diversity_ant_sel_i <= c[1];
      step(2); check(32'({ant1_o, ant2_o, diversity_en_o, diversity_beacon_o}),
                     32'({b, b, c[2], c[2] & c[1]}));
      wr(8'h1c, 8'h05);
      b = busy_tab[i];
      step(2); check(32'({ant1_o, ant2_o}), 32'({b, ~b}));
    end
    wr(8'h1c, 8'h01);
  endtask : t_antenna

  task automatic t_fifo_trim;
    wr(8'h20, 8'h03); check(32'(pulses), 32'h0000_0000);
    wr(8'h20, 8'h02); check(32'(pulses), 32'h0000_0001);
    wr(8'h20, 8'h00); check(32'(pulses), 32'h0000_0002);
    wr(8'h20, 8'h00); check(32'(pulses), 32'h0000_0000);
    wr(8'h24, 8'ha5);
    step(1); check(32'({xtal_trim_coarse_o, xtal_trim_fine_o}), 32'h0000_00a5);
    wb(1'b0, 8'h24, 8'h00, 4'h1); check(q, 32'h0000_00a5);
  endtask : t_fifo_trim

  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  always @(posedge clk_i) begin
    cycles++;
    if (cycles >= 20000) begin
      err_count++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_defaults();
    t_irq();
    t_mode_soft_reset();
    t_rx_tx();
    t_antenna();
    t_fifo_trim();
    stop_test();
  end
endmodule : testbench

`default_nettype wire
